// ==== hdl/pgbat_pkg.sv ====
// How it works
// RULE1: on a bad packet check while receiving, flush the fifo unless the keep bit is set
// RULE2: in standby the direction bit picks host writes (0) or host reads (1) of the fifo
// RULE3: page field bits 1..0 pick the page; 00 is page 0, 01 is page 1
// RULE4: the page register answers at the same index whatever page is selected
// RULE5: host keeps page 0 selected and returns there right after page 1 accesses; t_page also selects page 3 and t_batt reads irq status before returning
// RULE6: the page register resets to 0x00
// RULE7: config bit 3 switches the battery detector on; config resets to 0xb1
// RULE8: config bits 2..0 hold the battery threshold code, 000 lowest to 111 highest
// RULE9: status bit 7 is read only, 1 when the battery is above threshold
// RULE10: status bit 6 routes the detector result to its output pin
// RULE11: host preserves the reserved patterns 1011 and 010110 when writing
// RULE12: page bits 5..2 read zero and ignore writes; unused page codes select nothing
package pgbat_pkg;

  // wishbone geometry
  localparam int unsigned PGBAT_AW = 8;
  localparam int unsigned PGBAT_DW = 32;
  localparam int unsigned PGBAT_RW = 8;

  // register indices, byte address is four times the index
  localparam logic [5:0] PGBAT_IDX_BATT_CFG  = 6'h05;
  localparam logic [5:0] PGBAT_IDX_BATT_STAT = 6'h06;
  localparam logic [5:0] PGBAT_IDX_PAGE      = 6'h1f;
  localparam logic [5:0] PGBAT_IDX_IRQ_STAT  = 6'h20;
  localparam logic [5:0] PGBAT_IDX_IRQ_MASK  = 6'h21;
  localparam logic [5:0] PGBAT_IDX_LIVE      = 6'h22;

  // page register fields
  localparam int unsigned PGBAT_PG_KEEP_BIT = 7;
  localparam int unsigned PGBAT_PG_DIR_BIT  = 6;
  localparam int unsigned PGBAT_PG_SEL_LSB  = 0;
  localparam logic [7:0]  PGBAT_PG_WMASK    = 8'hc3;
  localparam logic [7:0]  PGBAT_PG_RST      = 8'h00;

  // battery config fields
  localparam int unsigned PGBAT_BC_ON_BIT   = 3;
  localparam int unsigned PGBAT_BC_THR_LSB  = 0;
  localparam logic [7:0]  PGBAT_BC_RST      = 8'hb1;

  // battery status fields
  localparam int unsigned PGBAT_BS_ABOVE_BIT = 7;
  localparam int unsigned PGBAT_BS_PIN_BIT   = 6;
  localparam logic [7:0]  PGBAT_BS_WMASK     = 8'h7f;
  localparam logic [7:0]  PGBAT_BS_RST       = 8'h96;

  // interrupt bits
  localparam int unsigned PGBAT_IRQ_W        = 4;
  localparam int unsigned PGBAT_IRQ_FLUSHED  = 0;
  localparam int unsigned PGBAT_IRQ_KEPT     = 1;
  localparam int unsigned PGBAT_IRQ_LOW_BATT = 2;
  localparam int unsigned PGBAT_IRQ_BAD_PAGE = 3;
  localparam logic [3:0]  PGBAT_IRQ_RST      = 4'h0;

  typedef enum logic [1:0] {
    PGBAT_PAGE0 = 2'b00,
    PGBAT_PAGE1 = 2'b01,
    PGBAT_PAGE2 = 2'b10,
    PGBAT_PAGE3 = 2'b11
  } pgbat_page_t;

  typedef enum logic [0:0] {
    PGBAT_BUS_IDLE = 1'b0,
    PGBAT_BUS_ACK  = 1'b1
  } pgbat_bus_t;

  typedef struct packed {
    logic                cyc;
    logic                stb;
    logic                we;
    logic [PGBAT_AW-1:0] adr;
    logic [3:0]          sel;
    logic [PGBAT_DW-1:0] dat;
  } pgbat_wb_req_t;

  typedef struct packed {
    logic                ack;
    logic [PGBAT_DW-1:0] dat;
  } pgbat_wb_rsp_t;

  typedef struct packed {
    logic flush;
    logic host_write;
    logic host_read;
  } pgbat_fifo_ctl_t;

  typedef struct packed {
    logic       on;
    logic [2:0] thr;
    logic       pin;
  } pgbat_batt_ctl_t;

  typedef struct packed {
    pgbat_bus_t          bus;
    logic [PGBAT_DW-1:0] rdata;
    logic [7:0]          page;
    logic [7:0]          bcfg;
    logic [7:0]          bstat;
    logic [3:0]          irq_stat;
    logic [3:0]          irq_mask;
    logic                above_d;
    pgbat_fifo_ctl_t     fifo;
    logic                pin;
    logic                irq;
  } pgbat_state_t;

endpackage

// ==== hdl/pgbat_sync2.sv ====
`timescale 1ns/1ps
module pgbat_sync2 (
  // clock and reset
  input  wire logic core_clk_in,
  input  wire logic rst_n_in,
  // async level in, synchronised level out
  input  wire logic async_in,
  output logic      sync_out
);

  logic meta_reg;
  logic sync_reg;

  // first stage feeds only the second stage
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;

endmodule

// ==== hdl/pgbat_regs.sv ====
`timescale 1ns/1ps
module pgbat_regs (
  // clock and reset
  input  wire logic                      core_clk_in,
  input  wire logic                      rst_n_in,
  // wishbone slave
  input  wire pgbat_pkg::pgbat_wb_req_t  wb_req_in,
  output pgbat_pkg::pgbat_wb_rsp_t       wb_rsp_out,
  // receive path and mode status
  input  wire logic                      rx_active_in,
  input  wire logic                      standby_in,
  input  wire logic                      crc_fail_in,
  // analog comparator result, asynchronous
  input  wire logic                      battery_above_in,
  // fifo control
  output pgbat_pkg::pgbat_fifo_ctl_t     fifo_ctl_out,
  // battery detector control and pin
  output pgbat_pkg::pgbat_batt_ctl_t     batt_ctl_out,
  // page currently selected
  output logic [1:0]                     page_out,
  // interrupt
  output logic                           irq_out
);
  import pgbat_pkg::*;

  pgbat_state_t state_reg;
  pgbat_state_t state_next;
  logic         above_sync;

  pgbat_sync2 u_above_sync (
    .core_clk_in (core_clk_in),
    .rst_n_in    (rst_n_in),
    .async_in    (battery_above_in),
    .sync_out    (above_sync)
  );

  // merge a byte write through a mask of writable bits
  function automatic logic [7:0] masked_write(
    input logic [7:0] old_val,
    input logic [7:0] new_val,
    input logic [7:0] wmask
  );
    masked_write = (old_val & ~wmask) | (new_val & wmask);
  endfunction

  // only code 01 opens page 1; 10 and 11 select nothing
  function automatic logic page1_open(input logic [7:0] page_val);
    page1_open = (page_val[PGBAT_PG_SEL_LSB +: 2] == PGBAT_PAGE1); // [RULE3] [RULE12]
  endfunction

  // sticky bits: a new event wins over a write-one clear in the same cycle
  function automatic logic [3:0] sticky_update(
    input logic [3:0] old_val,
    input logic [3:0] set_val,
    input logic [3:0] clr_val
  );
    sticky_update = (old_val & ~clr_val) | set_val;
  endfunction

  // bus request decode
  logic       req_taken;
  logic       req_write;
  logic [5:0] req_idx;
  logic       lane0;
  logic       hit_page;
  logic       hit_bcfg;
  logic       hit_bstat;
  logic       hit_istat;
  logic       hit_imask;
  logic       hit_live;

  always_comb begin
    req_taken = wb_req_in.cyc && wb_req_in.stb && (state_reg.bus == PGBAT_BUS_IDLE);
    req_write = req_taken && wb_req_in.we;
    req_idx   = wb_req_in.adr[PGBAT_AW-1:2];
    lane0     = wb_req_in.sel[0];
    hit_page  = (req_idx == PGBAT_IDX_PAGE); // [RULE4]
    hit_bcfg  = (req_idx == PGBAT_IDX_BATT_CFG) && page1_open(state_reg.page);
    hit_bstat = (req_idx == PGBAT_IDX_BATT_STAT) && page1_open(state_reg.page);
    hit_istat = (req_idx == PGBAT_IDX_IRQ_STAT);
    hit_imask = (req_idx == PGBAT_IDX_IRQ_MASK);
    hit_live  = (req_idx == PGBAT_IDX_LIVE);
  end

  // events
  logic       crc_bad_rx;
  logic       flush_now;
  logic       kept_now;
  logic       low_batt_now;
  logic       bad_page_now;
  logic [3:0] irq_set;
  logic [3:0] irq_clr;
  logic [7:0] wbyte;

  always_comb begin
    wbyte        = wb_req_in.dat[PGBAT_RW-1:0];
    crc_bad_rx   = crc_fail_in && rx_active_in;
    flush_now    = crc_bad_rx && !state_reg.page[PGBAT_PG_KEEP_BIT]; // [RULE1]
    kept_now     = crc_bad_rx && state_reg.page[PGBAT_PG_KEEP_BIT]; // [RULE1]
    // falling edge of the above-threshold level while the detector is on
    low_batt_now = state_reg.bcfg[PGBAT_BC_ON_BIT] && state_reg.above_d && !above_sync;
    bad_page_now = req_write && lane0 && hit_page && wbyte[1];
    irq_set                     = 4'h0;
    irq_set[PGBAT_IRQ_FLUSHED]  = flush_now;
    irq_set[PGBAT_IRQ_KEPT]     = kept_now;
    irq_set[PGBAT_IRQ_LOW_BATT] = low_batt_now;
    irq_set[PGBAT_IRQ_BAD_PAGE] = bad_page_now;
    irq_clr = (req_write && lane0 && hit_istat) ? wbyte[3:0] : 4'h0;
  end

  // read data for the addressed register
  logic [7:0] rbyte;
  logic [7:0] bstat_view;
  logic [7:0] page_view;
  logic [7:0] live_view;

  always_comb begin
    page_view  = state_reg.page & PGBAT_PG_WMASK; // [RULE12]
    bstat_view = state_reg.bstat & PGBAT_BS_WMASK;
    bstat_view[PGBAT_BS_ABOVE_BIT] = above_sync; // [RULE9]
    live_view    = 8'h00;
    live_view[0] = standby_in;
    live_view[1] = rx_active_in;
    live_view[2] = above_sync;
    live_view[3] = page1_open(state_reg.page);
    rbyte = 8'h00;
    if (hit_page) begin
      rbyte = page_view;
    end else if (hit_bcfg) begin
      rbyte = state_reg.bcfg;
    end else if (hit_bstat) begin
      rbyte = bstat_view;
    end else if (hit_istat) begin
      rbyte = {4'h0, state_reg.irq_stat};
    end else if (hit_imask) begin
      rbyte = {4'h0, state_reg.irq_mask};
    end else if (hit_live) begin
      rbyte = live_view;
    end
  end

  // next state
  always_comb begin
    state_next         = state_reg;
    state_next.above_d = above_sync;

    unique case (state_reg.bus)
      PGBAT_BUS_IDLE: begin
        if (req_taken) begin
          state_next.bus   = PGBAT_BUS_ACK;
          state_next.rdata = wb_req_in.we ? '0 : {24'h000000, rbyte};
        end
      end
      PGBAT_BUS_ACK: begin
        // ack lasts one cycle; the master drops stb before the next request
        state_next.bus = PGBAT_BUS_IDLE;
      end
    endcase

    if (req_write && lane0) begin
      if (hit_page) begin
        // bits 5..2 are not stored at all
        state_next.page = masked_write(state_reg.page, wbyte, PGBAT_PG_WMASK); // [RULE12]
      end
      if (hit_bcfg) begin
        // reserved upper nibble is stored as written; the host keeps it intact
        state_next.bcfg = wbyte; // [RULE7] [RULE8] [RULE11]
      end
      if (hit_bstat) begin
        state_next.bstat = masked_write(state_reg.bstat, wbyte, PGBAT_BS_WMASK); // [RULE9]
      end
      if (hit_imask) begin
        state_next.irq_mask = wbyte[3:0];
      end
    end

    state_next.irq_stat = sticky_update(state_reg.irq_stat, irq_set, irq_clr);
    state_next.irq      = |(state_next.irq_stat & state_next.irq_mask);

    // flush is high one cycle after each bad check cycle with the keep bit clear, registered for a clean output
    state_next.fifo.flush = flush_now; // [RULE1]
    // direction only matters in standby; outside it neither path is granted
    state_next.fifo.host_write = standby_in && !state_next.page[PGBAT_PG_DIR_BIT]; // [RULE2]
    state_next.fifo.host_read  = standby_in && state_next.page[PGBAT_PG_DIR_BIT]; // [RULE2]

    // pin shows the detector result only when mapped and the detector runs
    state_next.pin = state_next.bstat[PGBAT_BS_PIN_BIT] &&
                     state_next.bcfg[PGBAT_BC_ON_BIT] && above_sync; // [RULE10]
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      state_reg.bus      <= PGBAT_BUS_IDLE;
      state_reg.rdata    <= '0;
      state_reg.page     <= PGBAT_PG_RST; // [RULE6]
      state_reg.bcfg     <= PGBAT_BC_RST; // [RULE7]
      state_reg.bstat    <= PGBAT_BS_RST;
      state_reg.irq_stat <= PGBAT_IRQ_RST;
      state_reg.irq_mask <= PGBAT_IRQ_RST;
      state_reg.above_d  <= 1'b0;
      state_reg.fifo     <= '0;
      state_reg.pin      <= 1'b0;
      state_reg.irq      <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  // outputs
  always_comb begin
    wb_rsp_out.ack   = (state_reg.bus == PGBAT_BUS_ACK);
    wb_rsp_out.dat   = state_reg.rdata;
    fifo_ctl_out     = state_reg.fifo;
    batt_ctl_out.on  = state_reg.bcfg[PGBAT_BC_ON_BIT]; // [RULE7]
    batt_ctl_out.thr = state_reg.bcfg[PGBAT_BC_THR_LSB +: 3]; // [RULE8]
    batt_ctl_out.pin = state_reg.pin; // [RULE10]
    page_out         = state_reg.page[PGBAT_PG_SEL_LSB +: 2]; // [RULE3]
    irq_out          = state_reg.irq;
  end

endmodule

// ==== sim/pgbat_sva.sv ====
`timescale 1ns/1ps
module pgbat_sva (
  // watched ports
  input wire logic                       core_clk_in,
  input wire logic                       rst_n_in,
  input wire pgbat_pkg::pgbat_wb_req_t   wb_req_in,
  input wire pgbat_pkg::pgbat_wb_rsp_t   wb_rsp_out,
  input wire logic                       rx_active_in,
  input wire logic                       standby_in,
  input wire logic                       crc_fail_in,
  input wire pgbat_pkg::pgbat_fifo_ctl_t fifo_ctl_out,
  input wire pgbat_pkg::pgbat_batt_ctl_t batt_ctl_out,
  input wire logic [1:0]                 page_out
);
  import pgbat_pkg::*;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  a_ack_follows_take: assert property (
    wb_req_in.cyc && wb_req_in.stb && !wb_rsp_out.ack |=> wb_rsp_out.ack)
    else $error("request not answered in one cycle");
  a_ack_one_cycle: assert property (wb_rsp_out.ack |=> !wb_rsp_out.ack)
    else $error("ack held too long");
  a_rdata_upper_zero: assert property (
    wb_rsp_out.ack |-> wb_rsp_out.dat[31:8] == 24'h0) else $error("upper data not zero");
  a_flush_has_cause: assert property (
    fifo_ctl_out.flush |-> $past(crc_fail_in && rx_active_in)) else $error("flush without cause");
  a_dir_exclusive: assert property (
    !(fifo_ctl_out.host_write && fifo_ctl_out.host_read)) else $error("both directions");
  a_dir_tracks_standby: assert property ($past(rst_n_in) |->
    (fifo_ctl_out.host_write || fifo_ctl_out.host_read) == $past(standby_in))
    else $error("direction not tied to standby");
  a_reset_values: assert property (!$past(rst_n_in) |->
    page_out == 2'b00 && !batt_ctl_out.on && batt_ctl_out.thr == 3'b001)
    else $error("reset values wrong");
  a_pin_needs_on: assert property (batt_ctl_out.pin |-> batt_ctl_out.on)
    else $error("pin routed with detector off");
  a_page_by_write: assert property ($changed(page_out) |->
    $past(wb_req_in.cyc && wb_req_in.stb && wb_req_in.we && !wb_rsp_out.ack))
    else $error("page moved without a write");
endmodule
bind pgbat_regs pgbat_sva pgbat_sva_i (.core_clk_in, .rst_n_in, .wb_req_in, .wb_rsp_out,
  .rx_active_in, .standby_in, .crc_fail_in, .fifo_ctl_out, .batt_ctl_out, .page_out);

// ==== sim/pgbat_host.sv ====
`timescale 1ns/1ps
module pgbat_host (
  // clock and reset
  input  wire logic                     core_clk_in,
  input  wire logic                     rst_n_in,
  // commands from the bench
  input  wire logic                     go_in,
  input  wire logic                     we_in,
  input  wire logic [7:0]               adr_in,
  input  wire logic [7:0]               dat_in,
  // wishbone master side
  input  wire pgbat_pkg::pgbat_wb_rsp_t wb_rsp_in,
  output pgbat_pkg::pgbat_wb_req_t      wb_req_out,
  // completion
  output logic                          done_out,
  output logic [7:0]                    rdata_out
);
  import pgbat_pkg::*;
  // released write data is inverted so a stale value never passes for a good one
  always_ff @(posedge core_clk_in) begin
    done_out <= 1'b0;
    if (!rst_n_in) begin
      wb_req_out <= '0;
      rdata_out  <= 8'h00;
    end else if (wb_req_out.stb && wb_rsp_in.ack) begin
      rdata_out      <= wb_rsp_in.dat[7:0];
      done_out       <= 1'b1;
      wb_req_out.cyc <= 1'b0;
      wb_req_out.stb <= 1'b0;
      wb_req_out.dat <= ~wb_req_out.dat;
    end else if (go_in && !wb_req_out.stb) begin
      wb_req_out <= '{cyc: 1'b1, stb: 1'b1, we: we_in, adr: adr_in, sel: 4'h1,
                      dat: {24'h0, dat_in}};
    end
  end
endmodule

// ==== sim/test_page_select_low_battery_regs.sv ====
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
  $display("FAIL %s exp %h got %h", nm, e, g); end end
module test_page_select_low_battery_regs;
  import pgbat_pkg::*;
  logic            core_clk_in = 1'b0;
  logic            rst_n_in = 1'b0;
  logic            rx_active_in = 1'b0;
  logic            standby_in = 1'b0;
  logic            crc_fail_in = 1'b0;
  logic            battery_above_in = 1'b1;
  logic            go = 1'b0;
  logic            we = 1'b0;
  logic [7:0]      adr = 8'h00;
  logic [7:0]      wdat = 8'h00;
  logic [7:0]      rdat;
  logic            done;
  logic [1:0]      page;
  logic            irq;
  pgbat_wb_req_t   wb_req;
  pgbat_wb_rsp_t   wb_rsp;
  pgbat_fifo_ctl_t fifo_ctl;
  pgbat_batt_ctl_t batt_ctl;
  int              n_errors = 0;
  int              n_compared = 0;
  always #4 core_clk_in = ~core_clk_in;
  pgbat_host pgbat_host_i (.core_clk_in, .rst_n_in, .go_in(go), .we_in(we), .adr_in(adr),
    .dat_in(wdat), .wb_rsp_in(wb_rsp), .wb_req_out(wb_req), .done_out(done), .rdata_out(rdat));
  pgbat_regs pgbat_regs_i (.core_clk_in, .rst_n_in, .wb_req_in(wb_req), .wb_rsp_out(wb_rsp),
    .rx_active_in, .standby_in, .crc_fail_in, .battery_above_in, .fifo_ctl_out(fifo_ctl),
    .batt_ctl_out(batt_ctl), .page_out(page), .irq_out(irq));
  // one bus cycle; write acks return zero data, so every cycle checks its data
  task automatic bus(input int w, input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
    int i;
    @(posedge core_clk_in);
    go <= 1'b1;
    we <= w[0];
    adr <= a;
    wdat <= d;
    @(posedge core_clk_in);
    go <= 1'b0;
    for (i = 0; i < 20 && done !== 1'b1; i++) @(negedge core_clk_in);
    `CHK("bus done", 1'b1, done)
    // a missing answer is a hang, not a slow slave: end the run here
    if (done !== 1'b1) begin
      report_and_stop;
    end
    `CHK("bus data", e, rdat)
  endtask
  task automatic crc_pulse;
    @(posedge core_clk_in);
    crc_fail_in <= 1'b1;
    @(posedge core_clk_in);
    crc_fail_in <= 1'b0;
    @(negedge core_clk_in);
  endtask
  task automatic t_reset;
    bus(0, 8'h7c, 8'h00, 8'h00);
    bus(1, 8'h7c, 8'h01, 8'h00);
    bus(0, 8'h14, 8'h00, 8'hb1);
    bus(0, 8'h18, 8'h00, 8'h96);
    `CHK("thr", 3'b001, batt_ctl.thr)
    `CHK("on", 1'b0, batt_ctl.on)
    bus(1, 8'h7c, 8'h00, 8'h00);
    $display("t_reset done");
  endtask
  task automatic t_page;
    bus(0, 8'h14, 8'h00, 8'h00);
    bus(1, 8'h7c, 8'hff, 8'h00);
    bus(0, 8'h7c, 8'h00, 8'hc3);
    bus(0, 8'h14, 8'h00, 8'h00);
    `CHK("page", 2'b11, page)
    bus(1, 8'h7c, 8'h01, 8'h00);
    bus(0, 8'h7c, 8'h00, 8'h01);
    bus(1, 8'h7c, 8'h00, 8'h00);
    $display("t_page done");
  endtask
  task automatic t_batt;
    bus(1, 8'h7c, 8'h01, 8'h00);
    bus(1, 8'h14, 8'hbf, 8'h00);
    `CHK("on", 1'b1, batt_ctl.on)
    `CHK("thr", 3'b111, batt_ctl.thr)
    bus(1, 8'h18, 8'hd6, 8'h00);
    `CHK("pin up", 1'b1, batt_ctl.pin)
    @(posedge core_clk_in);
    battery_above_in <= 1'b0;
    repeat (4) @(posedge core_clk_in);
    bus(0, 8'h18, 8'h00, 8'h56);
    `CHK("pin low batt", 1'b0, batt_ctl.pin)
    bus(1, 8'h18, 8'h96, 8'h00);
    bus(0, 8'h18, 8'h00, 8'h16);
    @(posedge core_clk_in);
    battery_above_in <= 1'b1;
    repeat (4) @(posedge core_clk_in);
    `CHK("pin unrouted", 1'b0, batt_ctl.pin)
    bus(0, 8'h80, 8'h00, 8'h0c);
    bus(1, 8'h7c, 8'h00, 8'h00);
    $display("t_batt done");
  endtask
  task automatic t_fifo;
    bus(1, 8'h84, 8'h0c, 8'h00);
    `CHK("irq pending", 1'b1, irq)
    bus(1, 8'h80, 8'h0f, 8'h00);
    `CHK("irq clear", 1'b0, irq)
    @(posedge core_clk_in);
    standby_in <= 1'b1;
    bus(1, 8'h84, 8'h01, 8'h00);
    `CHK("host write", 1'b1, fifo_ctl.host_write)
    bus(0, 8'h88, 8'h00, 8'h05);
    bus(1, 8'h7c, 8'h40, 8'h00);
    `CHK("host read", 1'b1, fifo_ctl.host_read)
    `CHK("no write", 1'b0, fifo_ctl.host_write)
    @(posedge core_clk_in);
    standby_in <= 1'b0;
    rx_active_in <= 1'b1;
    bus(1, 8'h7c, 8'h00, 8'h00);
    crc_pulse;
    `CHK("flush", 1'b1, fifo_ctl.flush)
    `CHK("irq set", 1'b1, irq)
    bus(1, 8'h7c, 8'h80, 8'h00);
    crc_pulse;
    `CHK("kept", 1'b0, fifo_ctl.flush)
    bus(0, 8'h80, 8'h00, 8'h03);
    bus(1, 8'h80, 8'h01, 8'h00);
    `CHK("irq masked", 1'b0, irq)
    @(posedge core_clk_in);
    rx_active_in <= 1'b0;
    bus(1, 8'h7c, 8'h00, 8'h00);
    $display("t_fifo done");
  endtask
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    t_reset;
    t_page;
    t_batt;
    t_fifo;
    report_and_stop;
  end
  // the whole sequence needs well under a thousand cycles
  initial begin
    repeat (4000) @(posedge core_clk_in);
    n_errors++;
    report_and_stop;
  end
endmodule
